//--- src/pagp_defs.vh
// constants shared by the port A general purpose i/o block
`ifndef PAGP_DEFS_VH
`define PAGP_DEFS_VH

// ******************************************************
// port geometry
// ******************************************************
`define PAGP_PORT_W        8
`define PAGP_ALL_PORT_PINS 26
`define PAGP_BIT6          6
`define PAGP_BIT7          7
`define PAGP_LOW_MSB       5

// ******************************************************
// register indices, byte address is four times these
// ******************************************************
`define PAGP_IDX_W         8
`define PAGP_IDX_DATA      8'h00
`define PAGP_IDX_DIR       8'h04
`define PAGP_IDX_PULLUP    8'h0D
`define PAGP_IDX_TOPPU     8'h0E
`define PAGP_IDX_KBD       8'h1B

// ******************************************************
// bus address split
// ******************************************************
`define PAGP_IDX_LSB       2
`define PAGP_IDX_MSB       9
`define PAGP_UPPER_LSB     10
`define PAGP_HTRANS_ACT    1
`define PAGP_HRESP_OKAY    1'b0

// ******************************************************
// field positions
// ******************************************************
`define PAGP_SEL_BIT       7
`define PAGP_TOPPU_BIT     7

// ******************************************************
// reset values
// ******************************************************
`define PAGP_RST_DIR       8'h00
`define PAGP_RST_PULLUP    8'h00
`define PAGP_RST_TOPPU     1'b0
`define PAGP_RST_KBD       8'h00
`define PAGP_RST_PINS      8'h00
`define PAGP_RST_WORD      32'h00000000

`endif

//--- src/pagp_sync.v
// two flip-flop synchroniser for pins and outside levels
`timescale 1ns/10ps

module pagp_sync #(
   parameter WIDTH = 8
) (
   // clock
   input  wire             ref_clk,
   // asynchronous levels in
   input  wire [WIDTH-1:0] async_in,
   // synchronised levels out
   output reg  [WIDTH-1:0] sync_out
);

   // ******************************************************
   // stages
   // ******************************************************
   // first stage feeds only the second stage
   reg [WIDTH-1:0] stage1;

   always @(posedge ref_clk) begin
      stage1   <= async_in;
      sync_out <= stage1;
   end

endmodule // pagp_sync

//--- src/pagp_port_a.v
// port A general purpose i/o with pull-ups over an ahb-lite slave
`timescale 1ns/10ps
`include "pagp_defs.vh"

module pagp_port_a (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst_n,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg         hreadyout,
   output reg         hresp,
   output reg  [31:0] hrdata,
   // port pins
   input  wire [7:0]  pin_in,
   output reg  [7:0]  pin_out,
   output reg  [7:0]  pin_oe,
   output reg  [7:0]  pin_pullup_en,
   // oscillator sharing on bit 6
   input  wire        oscillator_type_select,
   input  wire        rc_oscillator_clock,
   // keyboard interrupt unit side
   output reg  [7:0]  keyboard_pin_irq_enable,
   output reg  [7:0]  keyboard_pin_level
);

   // ******************************************************
   // functions
   // ******************************************************
   // word hit: aligned, in range, index matches
   function reg_hit;
      input [31:0]              addr;
      input [`PAGP_IDX_W-1:0]   idx;
      begin
         reg_hit = (addr[31:`PAGP_UPPER_LSB] == 22'h000000) &&
                   (addr[`PAGP_IDX_LSB-1:0] == 2'h0) &&
                   (addr[`PAGP_IDX_MSB:`PAGP_IDX_LSB] == idx);
      end
   endfunction

   // per-bit pick of latch or pin by direction
   function [7:0] gpio_read;
      input [7:0] dir_v;
      input [7:0] latch_v;
      input [7:0] pin_v;
      begin
         gpio_read = (dir_v & latch_v) | (~dir_v & pin_v);
      end
   endfunction

   // ******************************************************
   // synchronisers
   // ******************************************************
   wire [9:0] sync_bus;
   wire [7:0] pin_sync;
   wire       osc_xtal;
   wire       rc_clk_sync;

   pagp_sync #(
      .WIDTH    (10)
   ) u_sync (
      .ref_clk  (ref_clk),
      .async_in ({rc_oscillator_clock, oscillator_type_select, pin_in}),
      .sync_out (sync_bus)
   );

   assign pin_sync    = sync_bus[7:0];
   assign osc_xtal    = sync_bus[8];
   assign rc_clk_sync = sync_bus[9];

   // ******************************************************
   // registers
   // ******************************************************
   reg  [7:0]            port_a_data_latch;
   reg  [7:0]            port_a_direction;
   reg  [7:0]            port_a_pullup_enable;
   reg                   top_pin_pullup_enable;
   reg  [7:0]            keyboard_irq_enable_reg;

   reg  [7:0]            next_port_a_data_latch;
   reg  [7:0]            next_port_a_direction;
   reg  [7:0]            next_port_a_pullup_enable;
   reg                   next_top_pin_pullup_enable;
   reg  [7:0]            next_keyboard_irq_enable_reg;

   // data phase bookkeeping
   reg                   wr_pend;
   reg  [31:0]           wr_addr;

   // ******************************************************
   // address phase decode
   // ******************************************************
   wire take;
   wire take_rd;

   // hsize is ignored: only whole-word transfers are expected
   assign take    = hsel & htrans[`PAGP_HTRANS_ACT] & hready;
   assign take_rd = take & ~hwrite;

   // ******************************************************
   // next register values
   // ******************************************************
   always @* begin
      next_port_a_data_latch       = port_a_data_latch;
      next_port_a_direction        = port_a_direction;
      next_port_a_pullup_enable    = port_a_pullup_enable;
      next_top_pin_pullup_enable   = top_pin_pullup_enable;
      next_keyboard_irq_enable_reg = keyboard_irq_enable_reg;
      if (wr_pend) begin
         if (reg_hit(wr_addr, `PAGP_IDX_DATA)) begin
            // latch follows every write, input or output
            next_port_a_data_latch = hwdata[7:0];
         end
         if (reg_hit(wr_addr, `PAGP_IDX_DIR)) begin
            next_port_a_direction = hwdata[7:0];
         end
         if (reg_hit(wr_addr, `PAGP_IDX_PULLUP)) begin
            next_port_a_pullup_enable = hwdata[7:0];
         end
         if (reg_hit(wr_addr, `PAGP_IDX_TOPPU)) begin
            next_top_pin_pullup_enable = hwdata[`PAGP_TOPPU_BIT];
         end
         if (reg_hit(wr_addr, `PAGP_IDX_KBD)) begin
            next_keyboard_irq_enable_reg = hwdata[7:0];
         end
      end
   end

   // ******************************************************
   // register storage
   // ******************************************************
   // latch has no reset so contents survive a system reset
   always @(posedge ref_clk) begin
      port_a_data_latch <= next_port_a_data_latch;
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         port_a_direction        <= `PAGP_RST_DIR;
         port_a_pullup_enable    <= `PAGP_RST_PULLUP;
         top_pin_pullup_enable   <= `PAGP_RST_TOPPU;
         keyboard_irq_enable_reg <= `PAGP_RST_KBD;
      end else begin
         port_a_direction        <= next_port_a_direction;
         port_a_pullup_enable    <= next_port_a_pullup_enable;
         top_pin_pullup_enable   <= next_top_pin_pullup_enable;
         keyboard_irq_enable_reg <= next_keyboard_irq_enable_reg;
      end
   end

   // ******************************************************
   // bit 6 sharing
   // ******************************************************
   wire bit6_pin_io_select;
   wire bit6_gpio;
   wire bit6_clk_out;
   wire next_bit6_gpio;

   assign bit6_pin_io_select = port_a_pullup_enable[`PAGP_SEL_BIT];

   // crystal option hands the pin to the oscillator
   assign bit6_gpio    = ~osc_xtal & bit6_pin_io_select;
   assign bit6_clk_out = ~osc_xtal & ~bit6_pin_io_select;

   // forwarded copy so a read right after a write sees new mode
   assign next_bit6_gpio = ~osc_xtal &
                           next_port_a_pullup_enable[`PAGP_SEL_BIT];

   // ******************************************************
   // pin drive
   // ******************************************************
   wire [7:0] pu_bits;
   wire [7:0] gp_mask;

   assign pu_bits = {top_pin_pullup_enable,
                     port_a_pullup_enable[`PAGP_BIT6:0]};

   // bit 6 drops out of gpio use unless selected with the crystal option off
   assign gp_mask = {1'b1, bit6_gpio, {(`PAGP_LOW_MSB+1){1'b1}}};

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         pin_out       <= `PAGP_RST_PINS;
         pin_oe        <= `PAGP_RST_PINS;
         pin_pullup_en <= `PAGP_RST_PINS;
      end else begin
         pin_out       <= port_a_data_latch;
         pin_oe        <= port_a_direction & gp_mask;
         // pull-up only on inputs, never on outputs
         pin_pullup_en <= pu_bits & ~port_a_direction & gp_mask;
         if (bit6_clk_out) begin
            // select bit overrides direction, pull-up and keyboard
            pin_out[`PAGP_BIT6]       <= rc_clk_sync;
            pin_oe[`PAGP_BIT6]        <= 1'b1;
            pin_pullup_en[`PAGP_BIT6] <= 1'b0;
         end
      end
   end

   // ******************************************************
   // keyboard interrupt unit feed
   // ******************************************************
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         keyboard_pin_irq_enable <= `PAGP_RST_KBD;
         keyboard_pin_level      <= `PAGP_RST_PINS;
      end else begin
         // only pins in gpio use may act as interrupt inputs
         keyboard_pin_irq_enable <= keyboard_irq_enable_reg &
                                    gp_mask;
         keyboard_pin_level      <= pin_sync & gp_mask;
      end
   end

   // ******************************************************
   // read data
   // ******************************************************
   // built from next values so back to back write-read stays coherent
   reg [7:0] rd_byte;
   reg [7:0] data_rd;

   always @* begin
      data_rd = gpio_read(next_port_a_direction,
                          next_port_a_data_latch,
                          pin_sync);
      if (!next_bit6_gpio) begin
         data_rd[`PAGP_BIT6] = 1'b0;
      end
      rd_byte = 8'h00;
      if (reg_hit(haddr, `PAGP_IDX_DATA)) begin
         rd_byte = data_rd;
      end
      if (reg_hit(haddr, `PAGP_IDX_DIR)) begin
         rd_byte = next_port_a_direction;
      end
      if (reg_hit(haddr, `PAGP_IDX_PULLUP)) begin
         rd_byte = next_port_a_pullup_enable;
      end
      if (reg_hit(haddr, `PAGP_IDX_TOPPU)) begin
         rd_byte[`PAGP_TOPPU_BIT] = next_top_pin_pullup_enable;
      end
      if (reg_hit(haddr, `PAGP_IDX_KBD)) begin
         rd_byte = next_keyboard_irq_enable_reg;
      end
   end

   // ******************************************************
   // ahb-lite slave
   // ******************************************************
   // zero wait states, so hreadyout never drops
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= `PAGP_HRESP_OKAY;
         hrdata    <= `PAGP_RST_WORD;
         wr_pend   <= 1'b0;
         wr_addr   <= `PAGP_RST_WORD;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= `PAGP_HRESP_OKAY;
         wr_pend   <= take & hwrite;
         if (take) begin
            wr_addr <= haddr;
         end
         if (take_rd) begin
            hrdata <= {24'h000000, rd_byte};
         end else begin
            hrdata <= `PAGP_RST_WORD;
         end
      end
   end

endmodule // pagp_port_a

//--- tb/pagp_port_a_monitor.sv
// assertion checker for the port A i/o block
`timescale 1ns/10ps
module pagp_port_a_monitor (
   // clock, reset and bus
   input wire        ref_clk,
   input wire        rst_n,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata,
   // pins and shared functions
   input wire [7:0]  pin_out,
   input wire [7:0]  pin_oe,
   input wire [7:0]  pin_pullup_en,
   input wire        oscillator_type_select,
   input wire [7:0]  keyboard_pin_irq_enable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire take = hsel && htrans[1] && hready;

   property p_rst_dir;
      $rose(rst_n) |-> pin_oe == 8'h00;
   endproperty
   a_rst_dir: assert property (p_rst_dir)
      else $error("pins driven right after reset");
   property p_pu_off;
      (pin_pullup_en & pin_oe) == 8'h00;
   endproperty
   a_pu_off: assert property (p_pu_off)
      else $error("pull-up on an output pin");
   property p_rd_idle;
      !(take && !hwrite) |=> hrdata == 32'h00000000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside data phase");
   property p_upper;
      hrdata[31:8] == 24'h000000;
   endproperty
   a_upper: assert property (p_upper)
      else $error("upper read bits set");
   // register written at edge two, pad follows one edge later
   property p_dir_oe;
      take && hwrite && haddr == 32'h00000010 ##1 1'b1
         |-> ##2 pin_oe[5:0] == $past(hwdata[5:0], 2);
   endproperty
   a_dir_oe: assert property (p_dir_oe)
      else $error("enable does not follow direction");
   property p_lat_out;
      take && hwrite && haddr == 32'h00000000 ##1 1'b1
         |-> ##2 pin_out[5:0] == $past(hwdata[5:0], 2);
   endproperty
   a_lat_out: assert property (p_lat_out)
      else $error("drive value does not follow latch");
   property p_xtal;
      oscillator_type_select [*5] |-> !pin_oe[6] && !pin_pullup_en[6];
   endproperty
   a_xtal: assert property (p_xtal)
      else $error("bit 6 pad used in crystal mode");
   property p_xtal_kbd;
      oscillator_type_select [*5] |-> !keyboard_pin_irq_enable[6];
   endproperty
   a_xtal_kbd: assert property (p_xtal_kbd)
      else $error("bit 6 keyboard enable in crystal mode");
endmodule // pagp_port_a_monitor

bind pagp_port_a pagp_port_a_monitor u_mon (.ref_clk, .rst_n, .hsel,
   .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .pin_out,
   .pin_oe, .pin_pullup_en, .oscillator_type_select,
   .keyboard_pin_irq_enable);

//--- tb/pagp_pins.sv
// board model: pads, pull-ups and outside drivers of port A
`timescale 1ns/10ps
module pagp_pins (
   // device side
   input  wire       ref_clk,
   input  wire [7:0] pin_out,
   input  wire [7:0] pin_oe,
   input  wire [7:0] pin_pullup_en,
   // board side
   input  wire [7:0] ext_val,
   input  wire [7:0] ext_en,
   output wire [7:0] pin_in
);
   reg [7:0] flt = 8'h00;
   // an open pad holds no level: flip it every cycle
   always @(posedge ref_clk) flt <= ~pin_in;
   assign pin_in = (pin_oe & pin_out)
      | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pin_pullup_en | flt));
endmodule // pagp_pins

//--- tb/pagp_port_a_tb_top.sv
// self-checking bench for the port A i/o block
`timescale 1ns/10ps
`define CHK(n,e,g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value %s exp %0h got %0h", n, e, g); end end
module pagp_port_a_tb_top;
   reg         ref_clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   reg         oscillator_type_select = 1'h0, rc_oscillator_clock = 1'h0;
   reg  [1:0]  htrans = 2'h0;
   reg  [2:0]  hsize = 3'h2;
   reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   reg  [7:0]  ext_val = 8'h00, ext_en = 8'hFF;
   reg  [7:0]  lat, dir, pu, top, kbd, pb, upin, pexp;
   wire        hreadyout, hresp;
   wire        hready = hreadyout;
   wire [31:0] hrdata;
   wire [7:0]  pin_in, pin_out, pin_oe, pin_pullup_en;
   wire [7:0]  keyboard_pin_irq_enable, keyboard_pin_level;
   int         err_count = 0, cmp_count = 0, seed = 87, i;

   pagp_port_a u_pagp_port_a (
      .ref_clk                 (ref_clk),
      .rst_n                   (rst_n),
      .hsel                    (hsel),
      .haddr                   (haddr),
      .htrans                  (htrans),
      .hwrite                  (hwrite),
      .hsize                   (hsize),
      .hwdata                  (hwdata),
      .hready                  (hready),
      .hreadyout               (hreadyout),
      .hresp                   (hresp),
      .hrdata                  (hrdata),
      .pin_in                  (pin_in),
      .pin_out                 (pin_out),
      .pin_oe                  (pin_oe),
      .pin_pullup_en           (pin_pullup_en),
      .oscillator_type_select  (oscillator_type_select),
      .rc_oscillator_clock     (rc_oscillator_clock),
      .keyboard_pin_irq_enable (keyboard_pin_irq_enable),
      .keyboard_pin_level      (keyboard_pin_level)
   );
   pagp_pins   u_pagp_pins (
      .ref_clk                 (ref_clk),
      .pin_out                 (pin_out),
      .pin_oe                  (pin_oe),
      .pin_pullup_en           (pin_pullup_en),
      .ext_val                 (ext_val),
      .ext_en                  (ext_en),
      .pin_in                  (pin_in)
   );
   initial forever #20 ref_clk = ~ref_clk;

   task print_verdict;
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic bus(input reg w, input reg [7:0] a, input reg [7:0] d);
      int n;
      n = 0;
      hsel <= 1'h1; htrans <= 2'h2; hwrite <= w; haddr <= {22'h0, a, 2'h0};
      do begin @(posedge ref_clk); n++; end while (hready !== 1'h1 && n < 9);
      // each phase gets its own bound, so a stuck address phase fails too
      if (hready === 1'h1) begin
         hsel <= 1'h0; htrans <= 2'h0; hwdata <= {24'h0, d};
         n = 0;
         do begin @(posedge ref_clk); n++; end
            while (hready !== 1'h1 && n < 9);
         rd = hrdata;
      end
      if (hready !== 1'h1) begin
         err_count++;
         print_verdict;
      end
   endtask
   task wr(input reg [7:0] a, input reg [7:0] d); bus(1'h1, a, d); endtask
   task rchk(input reg [7:0] a, input reg [7:0] e);
      bus(1'h0, a, 8'h00);
      `CHK("rdata", {24'h0, e}, rd)
      `CHK("resp", 1'h0, hresp)
   endtask
   task do_reset;
      rst_n <= 1'h0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'h1;
      @(posedge ref_clk);
   endtask

   initial begin
      do_reset;
      rchk(8'h04, 8'h00);
      rchk(8'h0D, 8'h00);
      rchk(8'h1B, 8'h00);
      `CHK("oe", 8'h40, pin_oe)
      for (i = 0; i < 12; i++) begin
         lat = $random(seed); dir = $random(seed); pu = $random(seed);
         top = $random(seed); kbd = $random(seed); upin = $random(seed);
         pb = {top[7], pu[6:0]};
         ext_val <= upin;
         ext_en <= ~pb;
         wr(8'h0D, pu | 8'h80);
         wr(8'h0E, top);
         wr(8'h00, ~lat);
         wr(8'h04, dir);
         wr(8'h00, lat);
         wr(8'h1B, kbd);
         wr(8'h05, 8'hFF);
         repeat (6) @(posedge ref_clk);
         // outputs show the latch, inputs the board or the pull-up
         pexp = (dir & lat) | (~dir & ((upin & ~pb) | pb));
         rchk(8'h00, pexp);
         rchk(8'h04, dir);
         rchk(8'h0D, pu | 8'h80);
         rchk(8'h0E, top & 8'h80);
         rchk(8'h1B, kbd);
         `CHK("oe", dir, pin_oe)
         `CHK("pull", pb & ~dir, pin_pullup_en)
         `CHK("out", lat, pin_out)
         `CHK("kbd", kbd, keyboard_pin_irq_enable)
         `CHK("klev", pexp, keyboard_pin_level)
      end
      do_reset;
      rchk(8'h04, 8'h00);
      wr(8'h0D, 8'h80);
      wr(8'h04, 8'hFF);
      rchk(8'h00, lat);
      rc_oscillator_clock <= 1'h1;
      oscillator_type_select <= 1'h1;
      wr(8'h1B, 8'hFF);
      repeat (6) @(posedge ref_clk);
      `CHK("oe6", 1'h0, pin_oe[6])
      `CHK("klev6", 1'h0, keyboard_pin_level[6])
      rchk(8'h00, lat & 8'hBF);
      oscillator_type_select <= 1'h0;
      wr(8'h0D, 8'h00);
      repeat (6) @(posedge ref_clk);
      `CHK("rc_oscillator_clock", 2'h3, {pin_oe[6], pin_out[6]})
      `CHK("kbd6", 1'h0, keyboard_pin_irq_enable[6])
      rc_oscillator_clock <= 1'h0;
      repeat (6) @(posedge ref_clk);
      `CHK("rc_oscillator_clock", 2'h2, {pin_oe[6], pin_out[6]})
      print_verdict;
   end
endmodule // pagp_port_a_tb_top
